// ### logic/tc_chan.sv
// one 16-bit timer/counter capture channel with block registers, apb slave
`timescale 1ns/1ps
`include "tc_chan_defs.svh"
module tc_chan
   import tc_chan_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic i_sync,
   output logic o_block_sync,
   input wire logic [2:0] i_ext_clock_pins,
   input wire logic [1:0] i_peer_line_a,
   input wire logic i_io_line_a,
   input wire logic i_io_line_b,
   output logic o_io_line_a,
   output logic o_io_line_a_oe,
   output logic o_io_line_b,
   output logic o_io_line_b_oe,
   output logic o_irq
);
   // edge selector: 0 none, 1 rising, 2 falling, 3 both
   function automatic logic edge_hit(input logic [1:0] sel, input logic rise,
                                     input logic fall);
      edge_hit = (sel[0] & rise) | (sel[1] & fall);
   endfunction

   // register file
   logic [31:0] mode_q; // channel_mode_reg
   logic [5:0] blk_mode_q; // block_mode_reg, two bits per external input
   logic [15:0] cv_q; // counter_value_reg
   logic [15:0] cap_a_q; // capture_a
   logic [15:0] cap_b_q; // capture_b
   logic [15:0] top_q; // top_compare
   events_t flags_q; // sticky part of channel_status_reg
   logic [7:0] mask_q; // interrupt mask
   clk_state_t state_q; // clock control state
   logic trig_pend_q; // trigger waiting for the next active edge
   logic a_done_q; // capture A taken since trigger or last B
   logic a_unread_q; // capture A not yet read by software
   logic b_unread_q; // capture B not yet read by software
   logic moved_q; // counter changed last cycle
   logic [9:0] presc_q; // master clock divider
   logic lvl_prev_q; // previous selected clock level
   logic [2:0] xs1_q, xs2_q; // pin clock synchronisers
   logic [1:0] ps1_q, ps2_q; // peer line synchronisers
   logic as1_q, as2_q, a_prev_q; // line A synchroniser and edge history
   logic bs1_q, bs2_q, b_prev_q; // line B synchroniser and edge history
   logic [2:0] xc_prev_q; // external input history for event edges

   // apb strobes: access phase waits one cycle so the answer comes from flops
   logic acc, wr, rd;
   assign acc = psel & penable & pready;
   assign wr = acc & pwrite;
   assign rd = acc & ~pwrite;

   // mode fields
   logic wave;
   logic [2:0] clk_sel;
   logic [1:0] burst;
   assign wave = mode_q[`MODE_WAVE];
   assign clk_sel = mode_q[`MODE_CLKSEL_LSB +: 3];
   assign burst = mode_q[`MODE_BURST_LSB +: 2];

   // two-stage synchronisers for every pin input
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         xs1_q <= 3'h0;
         xs2_q <= 3'h0;
         ps1_q <= 2'h0;
         ps2_q <= 2'h0;
         as1_q <= 1'b0;
         as2_q <= 1'b0;
         bs1_q <= 1'b0;
         bs2_q <= 1'b0;
      end else begin
         xs1_q <= i_ext_clock_pins;
         xs2_q <= xs1_q;
         ps1_q <= i_peer_line_a;
         ps2_q <= ps1_q;
         as1_q <= i_io_line_a;
         as2_q <= as1_q;
         bs1_q <= i_io_line_b;
         bs2_q <= bs1_q;
      end
   end

   // block routing of the three external inputs
   logic [2:0] xc;
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         case (blk_mode_q[2*i +: 2])
            2'h0: xc[i] = xs2_q[i]; // own pin
            2'h2: xc[i] = ps2_q[0]; // chained from a peer line A
            2'h3: xc[i] = ps2_q[1];
            default: xc[i] = 1'b0; // unconnected
         endcase
      end
   end

   // prescaler runs freely; divided clocks are its bits
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) presc_q <= 10'h000;
      else presc_q <= presc_q + 10'h001;
   end

   // counting clock selection, inversion and burst gating
   logic sel_lvl, lvl, gate, active;
   always_comb begin
      case (clk_sel)
         3'h0: sel_lvl = presc_q[0];
         3'h1: sel_lvl = presc_q[2];
         3'h2: sel_lvl = presc_q[4];
         3'h3: sel_lvl = presc_q[6];
         3'h4: sel_lvl = presc_q[9];
         3'h5: sel_lvl = xc[0];
         3'h6: sel_lvl = xc[1];
         default: sel_lvl = xc[2];
      endcase
   end
   assign lvl = sel_lvl ^ mode_q[`MODE_INVERT];
   assign gate = (burst == 2'h0) ? 1'b1 : xc[burst - 2'h1];
   // external clocks are sampled, so they must stay slower than the master clock
   assign active = lvl & ~lvl_prev_q & gate & (state_q == CLK_RUNNING);

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) lvl_prev_q <= 1'b0;
      else lvl_prev_q <= lvl;
   end

   // edge detection on the synchronised lines
   logic a_rise, a_fall, b_rise, b_fall;
   assign a_rise = as2_q & ~a_prev_q;
   assign a_fall = ~as2_q & a_prev_q;
   assign b_rise = bs2_q & ~b_prev_q;
   assign b_fall = ~bs2_q & b_prev_q;
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         a_prev_q <= 1'b0;
         b_prev_q <= 1'b0;
         xc_prev_q <= 3'h0;
      end else begin
         a_prev_q <= as2_q;
         b_prev_q <= bs2_q;
         xc_prev_q <= xc;
      end
   end

   // compare matches, checked the cycle after the counter moves
   logic cmp_a, cmp_b, cmp_top;
   assign cmp_a = moved_q & (cv_q == cap_a_q);
   assign cmp_b = moved_q & (cv_q == cap_b_q);
   assign cmp_top = moved_q & (cv_q == top_q);

   // external trigger: capture picks a line, waveform picks line B or an input
   logic ev_lvl, ev_prev, ext_trig;
   logic [1:0] trg_line;
   assign trg_line = mode_q[`MODE_TRG_LINE_LSB +: 2];
   always_comb begin
      if (!wave) begin
         ev_lvl = trg_line[0] ? as2_q : bs2_q;
         ev_prev = trg_line[0] ? a_prev_q : b_prev_q;
      end else if (trg_line == 2'h0) begin
         ev_lvl = bs2_q;
         ev_prev = b_prev_q;
      end else begin
         ev_lvl = xc[trg_line - 2'h1];
         ev_prev = xc_prev_q[trg_line - 2'h1];
      end
   end
   // edge field zero matches nothing, which disables the trigger
   assign ext_trig = edge_hit(mode_q[`MODE_TRG_EDGE_LSB +: 2], ev_lvl & ~ev_prev,
                              ~ev_lvl & ev_prev)
                     & (~wave | mode_q[`MODE_EXT_TRG_EN]);

   // all trigger sources merge here; block sync comes from its flop so this
   // channel acts on the same edge as the peers fed by o_block_sync
   logic sw_trig, blk_sync, trig;
   assign sw_trig = wr & (paddr == `OFS_CTRL) & pwdata[`CTRL_SW_TRIG];
   assign blk_sync = wr & (paddr == `OFS_BLK_CTRL) & pwdata[`BLK_SYNC];
   assign trig = sw_trig | i_sync | o_block_sync
                 | (cmp_top & mode_q[`MODE_TOP_TRG_EN])
                 | ext_trig;

   // capture loads on line A edges, in A-then-B order
   logic load_a, load_b;
   assign load_a = ~wave & ~a_done_q
                   & edge_hit(mode_q[`MODE_LOAD_A_LSB +: 2], a_rise, a_fall);
   assign load_b = ~wave & a_done_q
                   & edge_hit(mode_q[`MODE_LOAD_B_LSB +: 2], a_rise, a_fall);

   // stop and disable events from the mode-dependent source
   logic stop_ev, dis_ev;
   assign stop_ev = mode_q[`MODE_STOP] & (wave ? cmp_top : load_b);
   assign dis_ev = mode_q[`MODE_DISABLE] & (wave ? cmp_top : load_b);

   // clock control state
   logic clk_on, clk_off;
   assign clk_on = wr & (paddr == `OFS_CTRL) & pwdata[`CTRL_CLK_ON];
   assign clk_off = wr & (paddr == `OFS_CTRL) & pwdata[`CTRL_CLK_OFF];
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         state_q <= CLK_DISABLED;
      end else begin
         case (state_q)
            // only clock-on leaves the disabled state
            CLK_DISABLED: if (clk_on && !clk_off) state_q <= CLK_STOPPED;
            CLK_STOPPED: begin
               if (clk_off || dis_ev) state_q <= CLK_DISABLED;
               else if (trig) state_q <= CLK_RUNNING;
            end
            CLK_RUNNING: begin
               if (clk_off || dis_ev) state_q <= CLK_DISABLED;
               else if (stop_ev && !trig) state_q <= CLK_STOPPED;
            end
            default: state_q <= CLK_DISABLED;
         endcase
      end
   end

   // pending trigger; a new trigger on the consuming edge stays pending
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) trig_pend_q <= 1'b0;
      else trig_pend_q <= trig | (trig_pend_q & ~active);
   end

   // counter
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         cv_q <= `RST_VALUE;
         moved_q <= 1'b0;
      end else begin
         moved_q <= active;
         if (active && trig_pend_q) cv_q <= `RST_VALUE;
         else if (active) cv_q <= cv_q + 16'h0001;
      end
   end

   // capture registers, sequencing and unread tracking
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         cap_a_q <= `RST_VALUE;
         cap_b_q <= `RST_VALUE;
         a_done_q <= 1'b0;
         a_unread_q <= 1'b0;
         b_unread_q <= 1'b0;
      end else begin
         if (load_a) cap_a_q <= cv_q;
         else if (wr && wave && paddr == `OFS_CAP_A) cap_a_q <= pwdata[15:0];
         if (load_b) cap_b_q <= cv_q;
         else if (wr && wave && paddr == `OFS_CAP_B) cap_b_q <= pwdata[15:0];
         if (trig || load_b) a_done_q <= 1'b0;
         else if (load_a) a_done_q <= 1'b1;
         // a load in the read cycle counts as unread
         a_unread_q <= load_a | (a_unread_q & ~(rd && paddr == `OFS_CAP_A));
         b_unread_q <= load_b | (b_unread_q & ~(rd && paddr == `OFS_CAP_B));
      end
   end

   // sticky event flags; hardware set wins over the read clear
   events_t ev_set;
   always_comb begin
      ev_set = '0;
      ev_set.wrap = active & ~trig_pend_q & (cv_q == `MAX_VALUE);
      ev_set.overrun = (load_a & a_unread_q) | (load_b & b_unread_q);
      ev_set.cmp_a = cmp_a;
      ev_set.cmp_b = cmp_b;
      ev_set.cmp_top = cmp_top;
      ev_set.load_a = load_a;
      ev_set.load_b = load_b;
      ev_set.ext_trg = ext_trig;
   end
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) flags_q <= '0;
      else if (rd && paddr == `OFS_STATUS) flags_q <= ev_set;
      else flags_q <= flags_q | ev_set;
   end

   // writable configuration and interrupt mask
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         mode_q <= `RST_WORD;
         blk_mode_q <= 6'h00;
         top_q <= `RST_VALUE;
         mask_q <= 8'h00;
      end else if (wr) begin
         case (paddr)
            `OFS_MODE: mode_q <= pwdata;
            `OFS_BLK_MODE: blk_mode_q <= pwdata[5:0];
            `OFS_TOP: top_q <= pwdata[15:0];
            `OFS_IRQ_EN: mask_q <= mask_q | pwdata[7:0];
            `OFS_IRQ_DIS: mask_q <= mask_q & ~pwdata[7:0];
            default: mask_q <= mask_q;
         endcase
      end
   end

   // apb answer: one wait cycle, data and error taken from flops
   logic [31:0] rdata;
   logic mapped;
   always_comb begin
      rdata = 32'h0000_0000;
      mapped = 1'b1;
      case (paddr)
         `OFS_CTRL, `OFS_IRQ_EN, `OFS_IRQ_DIS, `OFS_BLK_CTRL: rdata = 32'h0000_0000;
         `OFS_MODE: rdata = mode_q;
         `OFS_VALUE: rdata = {16'h0000, cv_q};
         `OFS_CAP_A: rdata = {16'h0000, cap_a_q};
         `OFS_CAP_B: rdata = {16'h0000, cap_b_q};
         `OFS_TOP: rdata = {16'h0000, top_q};
         `OFS_STATUS: begin
            rdata[`NUM_EVENTS-1:0] = flags_q;
            rdata[`STATUS_CLK_ON] = (state_q != CLK_DISABLED);
         end
         `OFS_IRQ_MASK: rdata = {24'h000000, mask_q};
         `OFS_BLK_MODE: rdata = {26'h0000000, blk_mode_q};
         default: mapped = 1'b0;
      endcase
   end
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & penable & ~pready;
         prdata <= (psel && penable && !pready && !pwrite) ? rdata : 32'h0000_0000;
         pslverr <= psel & penable & ~pready & ~mapped;
      end
   end

   // waveform outputs: set on A/B compare, cleared on top compare
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_io_line_a <= 1'b0;
         o_io_line_b <= 1'b0;
         o_io_line_a_oe <= 1'b0;
         o_io_line_b_oe <= 1'b0;
      end else begin
         o_io_line_a_oe <= wave;
         // line B stays an input while it is the external event source
         o_io_line_b_oe <= wave & (trg_line != 2'h0);
         if (!wave || cmp_top) o_io_line_a <= 1'b0;
         else if (cmp_a) o_io_line_a <= 1'b1;
         if (!wave || cmp_top) o_io_line_b <= 1'b0;
         else if (cmp_b) o_io_line_b <= 1'b1;
      end
   end

   // block sync out to the peer channels and the interrupt line
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_block_sync <= 1'b0;
         o_irq <= 1'b0;
      end else begin
         o_block_sync <= blk_sync;
         o_irq <= |(flags_q & mask_q);
      end
   end

   // checks
   property p_wrap;
      @(posedge i_core_clk) disable iff (i_rst)
      active && !trig_pend_q && cv_q == 16'hffff |=> cv_q == 16'h0000 && flags_q.wrap;
   endproperty
   a_wrap: assert property (p_wrap) else $error("wrap flag not set");
   property p_trig_zero;
      @(posedge i_core_clk) disable iff (i_rst)
      active && trig_pend_q |=> cv_q == 16'h0000;
   endproperty
   a_trig_zero: assert property (p_trig_zero) else $error("trigger did not zero");
   property p_incr;
      @(posedge i_core_clk) disable iff (i_rst)
      active && !trig_pend_q |=> cv_q == $past(cv_q) + 16'h0001;
   endproperty
   a_incr: assert property (p_incr) else $error("counter did not step");
   property p_disabled_hold;
      @(posedge i_core_clk) disable iff (i_rst)
      state_q == CLK_DISABLED && !clk_on ##1 state_q == CLK_DISABLED |=> $stable(cv_q);
   endproperty
   a_disabled_hold: assert property (p_disabled_hold) else $error("count while off");
   property p_trig_starts;
      @(posedge i_core_clk) disable iff (i_rst)
      trig && state_q == CLK_STOPPED && !clk_off && !dis_ev |=> state_q == CLK_RUNNING;
   endproperty
   a_trig_starts: assert property (p_trig_starts) else $error("trigger no start");
   property p_b_after_a;
      @(posedge i_core_clk) disable iff (i_rst)
      load_b |-> a_done_q ##1 !a_done_q;
   endproperty
   a_b_after_a: assert property (p_b_after_a) else $error("B loaded out of order");
   property p_overrun;
      @(posedge i_core_clk) disable iff (i_rst)
      load_a && a_unread_q |=> flags_q.overrun && cap_a_q == $past(cv_q);
   endproperty
   a_overrun: assert property (p_overrun) else $error("overrun missed");
   property p_irq;
      @(posedge i_core_clk) disable iff (i_rst)
      ##1 o_irq == $past(|(flags_q & mask_q));
   endproperty
   a_irq: assert property (p_irq) else $error("irq mismatch");
   property p_clk_flag;
      @(posedge i_core_clk) disable iff (i_rst)
      clk_on && !clk_off && !dis_ev |=> state_q != CLK_DISABLED;
   endproperty
   a_clk_flag: assert property (p_clk_flag) else $error("clock-on ignored");
   c_wrap: cover property (@(posedge i_core_clk) disable iff (i_rst) ev_set.wrap);
   c_load_pair: cover property (@(posedge i_core_clk) disable iff (i_rst)
      load_a ##[1:200] load_b);
   c_overrun: cover property (@(posedge i_core_clk) disable iff (i_rst) ev_set.overrun);
endmodule

// ### logic/tc_chan_defs.svh
// register offsets, field positions, reset values and counts of the counter channel
`ifndef TC_CHAN_DEFS_SVH
`define TC_CHAN_DEFS_SVH
`define OFS_CTRL 8'h00
`define OFS_MODE 8'h04
`define OFS_VALUE 8'h10
`define OFS_CAP_A 8'h14
`define OFS_CAP_B 8'h18
`define OFS_TOP 8'h1c
`define OFS_STATUS 8'h20
`define OFS_IRQ_EN 8'h24
`define OFS_IRQ_DIS 8'h28
`define OFS_IRQ_MASK 8'h2c
`define OFS_BLK_CTRL 8'hc0
`define OFS_BLK_MODE 8'hc4
`define CTRL_CLK_ON 0
`define CTRL_CLK_OFF 1
`define CTRL_SW_TRIG 2
`define BLK_SYNC 0
`define MODE_CLKSEL_LSB 0
`define MODE_INVERT 3
`define MODE_BURST_LSB 4
`define MODE_STOP 6
`define MODE_DISABLE 7
`define MODE_TRG_EDGE_LSB 8
`define MODE_TRG_LINE_LSB 10
`define MODE_EXT_TRG_EN 12
`define MODE_TOP_TRG_EN 14
`define MODE_WAVE 15
`define MODE_LOAD_A_LSB 16
`define MODE_LOAD_B_LSB 18
`define STATUS_CLK_ON 16
`define RST_WORD 32'h0000_0000
`define RST_VALUE 16'h0000
`define MAX_VALUE 16'hffff
`define NUM_EVENTS 8
`endif

// ### logic/tc_chan_pkg.sv
// types shared by the counter channel
package tc_chan_pkg;
   // clock control: disabled, enabled but stopped, counting
   typedef enum logic [1:0] {CLK_DISABLED, CLK_STOPPED, CLK_RUNNING} clk_state_t;
   // sticky event flags, bit 7 downward
   typedef struct packed {
      logic ext_trg;
      logic load_b;
      logic load_a;
      logic cmp_top;
      logic cmp_b;
      logic cmp_a;
      logic overrun;
      logic wrap;
   } events_t;
endpackage

// ### verif/ext_clk_model.sv
// stand-in for the external clock source wired to the channel pins
`timescale 1ns/1ps
module ext_clk_model #(
   parameter int HALF = 3 // master periods per level
) (
   input wire logic i_core_clk,
   input wire logic i_run,
   output logic o_ext_clk
);
   logic clk_q = 1'b0; // current level of the source
   int cnt = 0; // master cycles spent in this level
   assign o_ext_clk = clk_q;
   // each level lasts several master periods so the synchroniser never misses one;
   // outside a run the line stands still at its last level
   always @(posedge i_core_clk) begin
      if (i_run) begin
         if (cnt == HALF - 1) begin
            cnt <= 0;
            clk_q <= ~clk_q;
         end else begin
            cnt <= cnt + 1;
         end
      end
   end
endmodule

// ### verif/tc_chan_tb.sv
// self-checking bench for the timer/counter capture channel
`timescale 1ns/1ps
`include "tc_chan_defs.svh"
module tc_chan_tb;
   logic core_clk, rst, psel, penable, pwrite, sync, line_a, line_b; // bench-driven inputs
   logic gate, on_peer, run, mclk, perr; // routing controls, model clock and last error flag
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q, q2; // bus data and last read words
   logic pready, pslverr, block_sync, la_o, la_oe, lb_o, lb_oe, irq; // design outputs
   int errors, tests_run, rise_n, fall_n;
   ext_clk_model #(.HALF(3)) i_model (.i_core_clk(core_clk), .i_run(run), .o_ext_clk(mclk));
   tc_chan i_dut (.i_core_clk(core_clk), .i_rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .i_sync(sync), .o_block_sync(block_sync),
      .i_ext_clock_pins({1'b0, gate, on_peer ? 1'b0 : mclk}),
      .i_peer_line_a({1'b0, on_peer ? mclk : 1'b0}), .i_io_line_a(line_a),
      .i_io_line_b(line_b), .o_io_line_a(la_o), .o_io_line_a_oe(la_oe), .o_io_line_b(lb_o),
      .o_io_line_b_oe(lb_oe), .o_irq(irq));
   // edges of the model clock, counted by the bench for the expected value
   always @(posedge mclk) rise_n++;
   always @(negedge mclk) fall_n++;
   // 25 mhz master clock
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // one apb transfer; request held until pready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      // back-to-back call: let the release edge pass before the next setup
      if (psel === 1'b1) @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      q = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         errors++;
         end_of_test();
      end
   endtask
   // 0: line a pulse, 1: line b pulse, 2: one-cycle sync pulse
   task automatic pulse(input int k);
      if (k == 2) begin
         sync <= 1'b1;
         @(posedge core_clk);
         sync <= 1'b0;
      end else begin
         if (k == 0) line_a <= 1'b1;
         else line_b <= 1'b1;
         cyc(10);
         line_a <= 1'b0;
         line_b <= 1'b0;
         cyc(10);
      end
   endtask
   // clock on then software trigger, as two separate writes
   task automatic start();
      apb(1'b1, `OFS_CTRL, 32'h1);
      apb(1'b1, `OFS_CTRL, 32'h4);
   endtask
   // reset values, unmapped address, line direction per mode
   task automatic t_reset();
      logic [7:0] ra[5] = '{`OFS_MODE, `OFS_VALUE, `OFS_CAP_A, `OFS_STATUS, `OFS_IRQ_MASK};
      foreach (ra[i]) begin
         apb(1'b0, ra[i], 32'h0);
         chk("reset word", q, `RST_WORD);
      end
      apb(1'b0, 8'h08, 32'h0);
      chk("unmapped error", {31'h0, perr}, 32'h1);
      chk("capture lines as inputs", {30'h0, la_oe, lb_oe}, 32'h0);
      apb(1'b1, `OFS_MODE, 32'h8000);
      cyc(2);
      chk("waveform drives a, b is event", {30'h0, la_oe, lb_oe}, 32'h2);
      apb(1'b1, `OFS_MODE, 32'h0);
   endtask
   // enable flag, live reads, disabled clock ignores a trigger
   task automatic t_ctrl();
      start();
      cyc(20);
      apb(1'b0, `OFS_STATUS, 32'h0);
      chk("clock enabled", {31'h0, q[`STATUS_CLK_ON]}, 32'h1);
      apb(1'b0, `OFS_VALUE, 32'h0);
      q2 = q;
      apb(1'b0, `OFS_VALUE, 32'h0);
      chk("live value moves", {31'h0, q != q2}, 32'h1);
      apb(1'b1, `OFS_CTRL, 32'h2);
      apb(1'b0, `OFS_STATUS, 32'h0);
      chk("clock disabled", {31'h0, q[`STATUS_CLK_ON]}, 32'h0);
      apb(1'b0, `OFS_VALUE, 32'h0);
      q2 = q;
      apb(1'b1, `OFS_CTRL, 32'h4);
      cyc(20);
      apb(1'b0, `OFS_VALUE, 32'h0);
      chk("trigger ignored while disabled", q, q2);
   endtask
   // external clock: own pin, chained peer line, burst gate, invert, gate closed
   task automatic t_ext();
      logic [31:0] md[5] = '{32'h5, 32'h5, 32'h25, 32'hd, 32'h25};
      logic [31:0] exp;
      for (int k = 0; k < 5; k++) begin
         on_peer <= (k == 1);
         gate <= (k != 4);
         apb(1'b1, `OFS_BLK_MODE, (k == 1) ? 32'h2 : 32'h0);
         apb(1'b1, `OFS_MODE, md[k]);
         start();
         cyc(8);
         rise_n = 0;
         fall_n = 0;
         run <= 1'b1;
         cyc(23);
         run <= 1'b0;
         cyc(10);
         apb(1'b0, `OFS_VALUE, 32'h0);
         exp = (k == 4) ? q2 : ((k == 3) ? fall_n : rise_n) - 1;
         chk("external edge count", q, exp);
         q2 = q;
      end
   endtask
   // line edge triggers with edge field off and on, sync input, block sync, top match
   task automatic t_trig();
      logic [31:0] md[3] = '{32'h400, 32'h100, 32'h400};
      logic seen;
      for (int k = 0; k < 3; k++) begin
         apb(1'b1, `OFS_MODE, md[k]);
         start();
         cyc(200);
         pulse(k);
         cyc(6);
         apb(1'b0, `OFS_VALUE, 32'h0);
         chk("counter restarted", {31'h0, q < 32'd40}, {31'h0, k != 0});
      end
      seen = 1'b0;
      apb(1'b1, `OFS_BLK_CTRL, 32'h1);
      repeat (4) begin
         @(posedge core_clk);
         if (block_sync === 1'b1) seen = 1'b1;
      end
      chk("block sync pulse", {31'h0, seen}, 32'h1);
      apb(1'b1, `OFS_TOP, 32'd20);
      apb(1'b1, `OFS_MODE, 32'h4000);
      start();
      repeat (6) begin
         cyc(7);
         apb(1'b0, `OFS_VALUE, 32'h0);
         chk("top match restarts", {31'h0, q <= 32'd20}, 32'h1);
      end
   endtask
   // capture loads, order, stop and disable on b load, overrun with interrupt
   task automatic t_cap();
      apb(1'b1, `OFS_MODE, 32'h90040);
      apb(1'b1, `OFS_IRQ_EN, 32'h2);
      start();
      cyc(20);
      pulse(0);
      apb(1'b0, `OFS_CAP_A, 32'h0);
      q2 = q;
      apb(1'b0, `OFS_CAP_B, 32'h0);
      chk("b captured after a", {31'h0, q > q2}, 32'h1);
      apb(1'b0, `OFS_STATUS, 32'h0);
      chk("load flags, still enabled", q & 32'h10062, 32'h10060);
      apb(1'b0, `OFS_VALUE, 32'h0);
      q2 = q;
      cyc(10);
      apb(1'b0, `OFS_VALUE, 32'h0);
      chk("stopped on b load", q, q2);
      repeat (2) begin
         apb(1'b1, `OFS_CTRL, 32'h4);
         cyc(4);
         pulse(0);
      end
      chk("overrun interrupt", {31'h0, irq}, 32'h1);
      apb(1'b0, `OFS_STATUS, 32'h0);
      chk("overrun flag", q & 32'h2, 32'h2);
      cyc(3);
      chk("interrupt cleared", {31'h0, irq}, 32'h0);
      apb(1'b1, `OFS_MODE, 32'h10000);
      apb(1'b1, `OFS_CTRL, 32'h4);
      cyc(4);
      pulse(0);
      apb(1'b0, `OFS_CAP_A, 32'h0);
      q2 = q;
      pulse(0);
      apb(1'b0, `OFS_CAP_A, 32'h0);
      chk("a not reloaded before b", q, q2);
      apb(1'b1, `OFS_MODE, 32'h90080);
      apb(1'b1, `OFS_CTRL, 32'h4);
      cyc(4);
      pulse(0);
      apb(1'b0, `OFS_STATUS, 32'h0);
      chk("disabled on b load", {31'h0, q[`STATUS_CLK_ON]}, 32'h0);
   endtask
   // waveform: lines set on a/b match, cleared and stopped on top match, line b event
   task automatic t_wave();
      apb(1'b1, `OFS_MODE, 32'h8440);
      apb(1'b1, `OFS_CAP_A, 32'd3);
      apb(1'b1, `OFS_CAP_B, 32'd6);
      apb(1'b1, `OFS_TOP, 32'd100);
      start();
      cyc(30);
      chk("lines set on a/b match", {28'h0, la_o, lb_o, la_oe, lb_oe}, 32'hf);
      cyc(300);
      chk("lines cleared on top match", {28'h0, la_o, lb_o, la_oe, lb_oe}, 32'h3);
      apb(1'b0, `OFS_VALUE, 32'h0);
      chk("stopped on top match", q, 32'd100);
      apb(1'b1, `OFS_MODE, 32'h9140);
      pulse(1);
      apb(1'b0, `OFS_VALUE, 32'h0);
      chk("line b event restarts", {31'h0, q < 32'd40}, 32'h1);
   endtask
   // every input set at time zero, reset held 12 cycles
   initial begin
      errors = 0;
      tests_run = 0;
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      sync = 1'b0;
      line_a = 1'b0;
      line_b = 1'b0;
      gate = 1'b0;
      on_peer = 1'b0;
      run = 1'b0;
      cyc(12);
      rst <= 1'b0;
      @(posedge core_clk);
      t_reset();
      t_ctrl();
      t_ext();
      t_trig();
      t_cap();
      t_wave();
      end_of_test();
   end
endmodule
